// ===== rtl/uart_clk_cmd.sv
// Clock select and command decode for two serial channels, APB slave
//
// Register access over APB was decided locally.
`timescale 1ns/1ns
module uart_clk_cmd #(
  parameter int unsigned PCLK_HZ    = uart_clk_cmd_pkg::PCLK_HZ_DEFAULT,
  parameter int unsigned CRYSTAL_HZ = uart_clk_cmd_pkg::CRYSTAL_HZ_DEFAULT
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        crystal_clock_input,
  input  wire logic        input_pin_three,
  input  wire logic        input_pin_four,
  input  wire logic        input_pin_five,
  input  wire logic        input_pin_six,
  input  wire logic        timer_tick,
  input  wire logic [1:0]  tx_idle,
  input  wire logic [1:0]  tx_fifo_room,
  output logic      [1:0]  rx_clk_tick,
  output logic      [1:0]  rx_clk_one_x,
  output logic      [1:0]  tx_clk_tick,
  output logic      [1:0]  tx_clk_one_x,
  output logic      [1:0]  rx_run,
  output logic      [1:0]  tx_run,
  output logic      [1:0]  transmit_ready_flag,
  output logic      [1:0]  transmit_empty_flag,
  output logic      [1:0]  rx_search_start,
  output logic      [1:0]  mode_register_pointer_reset,
  output logic      [1:0]  rx_reset,
  output logic      [1:0]  tx_reset,
  output logic      [1:0]  error_status_reset,
  output logic      [1:0]  break_change_clear,
  output logic      [1:0]  misc_cmd_strobe,
  output logic      [7:0]  misc_cmd_code
);

  typedef struct packed {
    logic [1:0][7:0] csr;
    logic [1:0][7:0] mode;
    logic [7:0]      aux;
    logic [1:0]      rx_en;
    logic [1:0]      tx_en;
    logic [1:0]      tx_rdy;
    logic [1:0]      tx_emt;
    logic [4:0]      pin_prev;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    logic [1:0]      rx_tick;
    logic [1:0]      rx_one_x;
    logic [1:0]      tx_tick;
    logic [1:0]      tx_one_x;
    logic [1:0]      rx_run;
    logic [1:0]      tx_run;
    logic [1:0]      rx_search;
    logic [1:0]      mr_ptr_rst;
    logic [1:0]      rx_rst;
    logic [1:0]      tx_rst;
    logic [1:0]      err_rst;
    logic [1:0]      brk_clr;
    logic [1:0]      misc_stb;
    logic [1:0][3:0] misc_code;
  } top_state_type;

  localparam int unsigned DW = uart_clk_cmd_pkg::DIV_W;

  top_state_type state_ff;
  top_state_type nxt_state;

  logic [4:0]        pin_sync_lvl;
  logic [4:0]        pin_rise;
  logic              crystal_step;
  logic [3:0][3:0]   sel_code;
  logic [3:0][DW-1:0] sel_div;
  logic [3:0]        div_tick;
  logic [3:0]        sel_pin;
  logic [3:0]        sel_tick;
  logic [3:0]        sel_one_x;
  logic [1:0]        cmd_wr;
  logic [1:0]        csr_wr;
  logic              write_go;
  logic [3:0]        wr_code;
  logic [1:0]        tx_kill;
  logic [1:0]        tx_wake;

  generate
    if (PCLK_HZ < uart_clk_cmd_pkg::MIN_CLOCK_RATIO * CRYSTAL_HZ) begin : g_bad_clock
      $error("uart_clk_cmd needs pclk at least four times the crystal rate");
    end
  endgenerate

  // Rate table expressed as crystal edges per 16x period
  function automatic logic [DW-1:0] baud_divisor(
    input uart_clk_cmd_pkg::rate_mode_type m,
    input logic                            set1,
    input logic [3:0]                      code
  );
    logic [DW-1:0] d;
    d = 13'h0001;
    case (m)
      uart_clk_cmd_pkg::RATE_EXT_II: begin
        case (code)
          4'h0: d = set1 ? 13'h0020 : 13'h0030;
          4'h1: d = 13'h0106;
          4'h2: d = 13'h00d6;
          4'h3: d = set1 ? 13'h0010 : 13'h000c;
          4'h4: d = 13'h0008;
          4'h5: d = 13'h0004;
          4'h6: d = 13'h0002;
          4'h7: d = set1 ? 13'h0073 : 13'h00dc;
          4'h8: d = 13'h0004;
          4'h9: d = 13'h0030;
          4'ha: d = set1 ? 13'h0010 : 13'h0004;
          4'hb: d = 13'h0018;
          4'hc: d = set1 ? 13'h000c : 13'h0006;
          default: d = 13'h0001;
        endcase
      end
      uart_clk_cmd_pkg::RATE_EXT_I: begin
        case (code)
          4'h0: d = set1 ? 13'h0200 : 13'h0300;
          4'h1: d = 13'h0830;
          4'h2: d = 13'h06b0;
          4'h3: d = set1 ? 13'h0100 : 13'h00c0;
          4'h4: d = 13'h0080;
          4'h5: d = 13'h0040;
          4'h6: d = 13'h0020;
          4'h7: d = set1 ? 13'h0073 : 13'h00dc;
          4'h8: d = 13'h0010;
          4'h9: d = 13'h0008;
          4'ha: d = set1 ? 13'h0080 : 13'h0020;
          4'hb: d = 13'h0004;
          4'hc: d = set1 ? 13'h0002 : 13'h0001;
          default: d = 13'h0001;
        endcase
      end
      default: begin
        case (code)
          4'h0: d = set1 ? 13'h0c00 : 13'h1200;
          4'h1: d = 13'h0830;
          4'h2: d = 13'h06b0;
          4'h3: d = set1 ? 13'h0600 : 13'h0480;
          4'h4: d = 13'h0300;
          4'h5: d = 13'h0180;
          4'h6: d = 13'h00c0;
          4'h7: d = set1 ? 13'h0073 : 13'h00dc;
          4'h8: d = 13'h0060;
          4'h9: d = 13'h0030;
          4'ha: d = set1 ? 13'h0080 : 13'h0020;
          4'hb: d = 13'h0018;
          4'hc: d = set1 ? 13'h000c : 13'h0006;
          default: d = 13'h0001;
        endcase
      end
    endcase
    return d;
  endfunction

  function automatic uart_clk_cmd_pkg::rate_mode_type rate_mode(input logic [7:0] mode);
    uart_clk_cmd_pkg::rate_mode_type r;
    r = uart_clk_cmd_pkg::RATE_NORMAL;
    if (mode[uart_clk_cmd_pkg::MODE_EXT_II_BIT]) begin
      r = uart_clk_cmd_pkg::RATE_EXT_II;
    end else if (mode[uart_clk_cmd_pkg::MODE_EXT_I_BIT]) begin
      r = uart_clk_cmd_pkg::RATE_EXT_I;
    end
    return r;
  endfunction

  pin_sync #(
    .WIDTH (5)
  ) u_pin_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({crystal_clock_input, input_pin_six, input_pin_five,
                input_pin_four, input_pin_three}),
    .sync_out (pin_sync_lvl)
  );

  assign pin_rise     = pin_sync_lvl & ~state_ff.pin_prev;
  assign crystal_step = pin_rise[4];

  // Selector order: 0 receiver A, 1 transmitter A, 2 receiver B, 3 transmitter B
  assign sel_code[0] = state_ff.csr[0][7:4];
  assign sel_code[1] = state_ff.csr[0][3:0];
  assign sel_code[2] = state_ff.csr[1][7:4];
  assign sel_code[3] = state_ff.csr[1][3:0];
  assign sel_pin[0]  = pin_rise[1];
  assign sel_pin[1]  = pin_rise[0];
  assign sel_pin[2]  = pin_rise[3];
  assign sel_pin[3]  = pin_rise[2];

  generate
    for (genvar i = 0; i < 4; i++) begin : g_sel
      assign sel_div[i] = baud_divisor(rate_mode(state_ff.mode[i/2]),
                                       state_ff.aux[uart_clk_cmd_pkg::AUX_RATE_SET_BIT],
                                       sel_code[i]);

      baud_divider #(
        .DIV_W (DW)
      ) u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .step    (crystal_step),
        .divisor (sel_div[i]),
        .tick    (div_tick[i])
      );

      always_comb begin
        if (sel_code[i] == uart_clk_cmd_pkg::SEL_TIMER) begin
          sel_tick[i] = timer_tick;
        end else if (sel_code[i] >= uart_clk_cmd_pkg::SEL_PIN_16) begin
          sel_tick[i] = sel_pin[i];
        end else begin
          sel_tick[i] = div_tick[i];
        end
      end

      // Only the 1x pin code hands the shifter an unscaled clock
      assign sel_one_x[i] = (sel_code[i] == uart_clk_cmd_pkg::SEL_PIN_1X);
    end
  endgenerate

  assign write_go = psel && penable && state_ff.pready && pwrite;
  assign wr_code  = pwdata[uart_clk_cmd_pkg::CMD_CODE_LSB +: 4];
  assign cmd_wr[0] = write_go && (paddr == uart_clk_cmd_pkg::ADDR_CHAN_A_COMMAND);
  assign cmd_wr[1] = write_go && (paddr == uart_clk_cmd_pkg::ADDR_CHAN_B_COMMAND);
  assign csr_wr[0] = write_go && (paddr == uart_clk_cmd_pkg::ADDR_CHAN_A_CLOCK_SELECT);
  assign csr_wr[1] = write_go && (paddr == uart_clk_cmd_pkg::ADDR_CHAN_B_CLOCK_SELECT);

  always_comb begin
    nxt_state            = state_ff;
    nxt_state.pready     = 1'b0;
    nxt_state.pslverr    = 1'b0;
    nxt_state.pin_prev   = pin_sync_lvl;
    nxt_state.rx_search  = '0;
    nxt_state.mr_ptr_rst = '0;
    nxt_state.rx_rst     = '0;
    nxt_state.tx_rst     = '0;
    nxt_state.err_rst    = '0;
    nxt_state.brk_clr    = '0;
    nxt_state.misc_stb   = '0;
    tx_kill              = '0;
    tx_wake              = '0;

    // Setup phase prepares the answer so the access phase ends on its first edge
    if (psel && !penable) begin
      nxt_state.pready = 1'b1;
      nxt_state.prdata = '0;
      if (paddr == uart_clk_cmd_pkg::ADDR_EXT_MODE_A) begin
        nxt_state.prdata[7:0] = state_ff.mode[0];
      end else if (paddr == uart_clk_cmd_pkg::ADDR_EXT_MODE_B) begin
        nxt_state.prdata[7:0] = state_ff.mode[1];
      end else if (paddr == uart_clk_cmd_pkg::ADDR_AUXILIARY_CONTROL) begin
        nxt_state.prdata[7:0] = state_ff.aux;
      end else if (paddr == uart_clk_cmd_pkg::ADDR_STATUS_A) begin
        nxt_state.prdata[5:0] = {state_ff.tx_run[0], state_ff.rx_run[0],
                                 state_ff.tx_emt[0], state_ff.tx_rdy[0],
                                 state_ff.tx_en[0], state_ff.rx_en[0]};
      end else if (paddr == uart_clk_cmd_pkg::ADDR_STATUS_B) begin
        nxt_state.prdata[5:0] = {state_ff.tx_run[1], state_ff.rx_run[1],
                                 state_ff.tx_emt[1], state_ff.tx_rdy[1],
                                 state_ff.tx_en[1], state_ff.rx_en[1]};
      end else if ((paddr == uart_clk_cmd_pkg::ADDR_CHAN_A_CLOCK_SELECT) ||
                   (paddr == uart_clk_cmd_pkg::ADDR_CHAN_A_COMMAND) ||
                   (paddr == uart_clk_cmd_pkg::ADDR_CHAN_B_CLOCK_SELECT) ||
                   (paddr == uart_clk_cmd_pkg::ADDR_CHAN_B_COMMAND)) begin
        nxt_state.prdata = '0;
      end else begin
        nxt_state.pslverr = 1'b1;
      end
    end

    if (write_go) begin
      if (paddr == uart_clk_cmd_pkg::ADDR_EXT_MODE_A) begin
        nxt_state.mode[0] = pwdata[7:0];
      end else if (paddr == uart_clk_cmd_pkg::ADDR_EXT_MODE_B) begin
        nxt_state.mode[1] = pwdata[7:0];
      end else if (paddr == uart_clk_cmd_pkg::ADDR_AUXILIARY_CONTROL) begin
        nxt_state.aux = pwdata[7:0];
      end
    end

    for (int c = 0; c < 2; c++) begin
      if (csr_wr[c]) begin
        nxt_state.csr[c] = pwdata[7:0];
      end
      if (cmd_wr[c]) begin
        if (pwdata[uart_clk_cmd_pkg::CMD_RX_ENABLE]) begin
          nxt_state.rx_en[c] = 1'b1;
          if (!state_ff.mode[c][uart_clk_cmd_pkg::MODE_WAKEUP_BIT]) begin
            nxt_state.rx_search[c] = 1'b1;
          end
        end
        // A disable written with an enable wins, the safer reading of a conflict
        if (pwdata[uart_clk_cmd_pkg::CMD_RX_DISABLE]) begin
          nxt_state.rx_en[c]     = 1'b0;
          nxt_state.rx_search[c] = 1'b0;
        end
        if (pwdata[uart_clk_cmd_pkg::CMD_TX_ENABLE]) begin
          nxt_state.tx_en[c] = 1'b1;
          tx_wake[c]         = 1'b1;
        end
        if (pwdata[uart_clk_cmd_pkg::CMD_TX_DISABLE]) begin
          nxt_state.tx_en[c] = 1'b0;
          tx_kill[c]         = 1'b1;
        end
        nxt_state.misc_code[c] = wr_code;
        case (wr_code)
          uart_clk_cmd_pkg::CMD_NOP: begin
          end
          uart_clk_cmd_pkg::CMD_MR_PTR_RESET: begin
            nxt_state.mr_ptr_rst[c] = 1'b1;
          end
          uart_clk_cmd_pkg::CMD_RX_RESET: begin
            nxt_state.rx_rst[c]    = 1'b1;
            nxt_state.rx_en[c]     = 1'b0;
            nxt_state.rx_search[c] = 1'b0;
          end
          uart_clk_cmd_pkg::CMD_TX_RESET: begin
            nxt_state.tx_rst[c] = 1'b1;
            nxt_state.tx_en[c]  = 1'b0;
            tx_kill[c]          = 1'b1;
          end
          uart_clk_cmd_pkg::CMD_ERR_RESET: begin
            nxt_state.err_rst[c] = 1'b1;
          end
          uart_clk_cmd_pkg::CMD_BRK_CLEAR: begin
            nxt_state.brk_clr[c] = 1'b1;
          end
          default: begin
            nxt_state.misc_stb[c] = 1'b1;
          end
        endcase
      end

      if (tx_kill[c]) begin
        nxt_state.tx_rdy[c] = 1'b0;
        nxt_state.tx_emt[c] = 1'b0;
      end else if (tx_wake[c] && tx_idle[c]) begin
        nxt_state.tx_rdy[c] = 1'b1;
        nxt_state.tx_emt[c] = 1'b1;
      end else if (state_ff.tx_en[c]) begin
        nxt_state.tx_rdy[c] = tx_fifo_room[c];
        nxt_state.tx_emt[c] = tx_idle[c];
      end

      // Disabled transmitter keeps shifting until its queue is empty
      nxt_state.tx_run[c] = nxt_state.tx_en[c] || !tx_idle[c];
      nxt_state.rx_run[c] = nxt_state.rx_en[c] ||
                            state_ff.mode[c][uart_clk_cmd_pkg::MODE_MULTIDROP_BIT];
    end

    nxt_state.rx_tick  = {sel_tick[2], sel_tick[0]};
    nxt_state.tx_tick  = {sel_tick[3], sel_tick[1]};
    nxt_state.rx_one_x = {sel_one_x[2], sel_one_x[0]};
    nxt_state.tx_one_x = {sel_one_x[3], sel_one_x[1]};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign prdata                     = state_ff.prdata;
  assign pready                     = state_ff.pready;
  assign pslverr                    = state_ff.pslverr;
  assign rx_clk_tick                = state_ff.rx_tick;
  assign rx_clk_one_x               = state_ff.rx_one_x;
  assign tx_clk_tick                = state_ff.tx_tick;
  assign tx_clk_one_x               = state_ff.tx_one_x;
  assign rx_run                     = state_ff.rx_run;
  assign tx_run                     = state_ff.tx_run;
  assign transmit_ready_flag        = state_ff.tx_rdy;
  assign transmit_empty_flag        = state_ff.tx_emt;
  assign rx_search_start            = state_ff.rx_search;
  assign mode_register_pointer_reset = state_ff.mr_ptr_rst;
  assign rx_reset                   = state_ff.rx_rst;
  assign tx_reset                   = state_ff.tx_rst;
  assign error_status_reset         = state_ff.err_rst;
  assign break_change_clear         = state_ff.brk_clr;
  assign misc_cmd_strobe            = state_ff.misc_stb;
  assign misc_cmd_code              = {state_ff.misc_code[1], state_ff.misc_code[0]};

endmodule // uart_clk_cmd

// ===== rtl/uart_clk_cmd_pkg.sv
// Shared constants for the dual-channel clock select and command block
package uart_clk_cmd_pkg;

  // Printed register indices; byte address is four times the index
  localparam int unsigned IDX_CHAN_A_CLOCK_SELECT = 32'h1;
  localparam int unsigned IDX_CHAN_A_COMMAND      = 32'h2;
  localparam int unsigned IDX_CHAN_B_CLOCK_SELECT = 32'h9;
  localparam int unsigned IDX_CHAN_B_COMMAND      = 32'ha;

  localparam int unsigned ADDR_W = 8;

  localparam logic [7:0] ADDR_CHAN_A_CLOCK_SELECT = 8'(IDX_CHAN_A_CLOCK_SELECT * 4);
  localparam logic [7:0] ADDR_CHAN_A_COMMAND      = 8'(IDX_CHAN_A_COMMAND * 4);
  localparam logic [7:0] ADDR_CHAN_B_CLOCK_SELECT = 8'(IDX_CHAN_B_CLOCK_SELECT * 4);
  localparam logic [7:0] ADDR_CHAN_B_COMMAND      = 8'(IDX_CHAN_B_COMMAND * 4);
  localparam logic [7:0] ADDR_EXT_MODE_A          = 8'h40;
  localparam logic [7:0] ADDR_EXT_MODE_B          = 8'h44;
  localparam logic [7:0] ADDR_AUXILIARY_CONTROL   = 8'h48;
  localparam logic [7:0] ADDR_STATUS_A            = 8'h50;
  localparam logic [7:0] ADDR_STATUS_B            = 8'h54;

  // Command register fields
  localparam int unsigned CMD_RX_ENABLE  = 0;
  localparam int unsigned CMD_RX_DISABLE = 1;
  localparam int unsigned CMD_TX_ENABLE  = 2;
  localparam int unsigned CMD_TX_DISABLE = 3;
  localparam int unsigned CMD_CODE_LSB   = 4;

  // Extended mode register and auxiliary control fields
  localparam int unsigned MODE_EXT_I_BIT     = 0;
  localparam int unsigned MODE_EXT_II_BIT    = 2;
  localparam int unsigned MODE_MULTIDROP_BIT = 3;
  localparam int unsigned MODE_WAKEUP_BIT    = 4;
  localparam int unsigned AUX_RATE_SET_BIT   = 7;

  // Status register fields
  localparam int unsigned STAT_RX_ENABLED = 0;
  localparam int unsigned STAT_TX_ENABLED = 1;
  localparam int unsigned STAT_TX_READY   = 2;
  localparam int unsigned STAT_TX_EMPTY   = 3;
  localparam int unsigned STAT_RX_RUN     = 4;
  localparam int unsigned STAT_TX_RUN     = 5;

  // Clock select codes
  localparam logic [3:0] SEL_TIMER  = 4'hd;
  localparam logic [3:0] SEL_PIN_16 = 4'he;
  localparam logic [3:0] SEL_PIN_1X = 4'hf;

  // Miscellaneous command codes
  localparam logic [3:0] CMD_NOP          = 4'h0;
  localparam logic [3:0] CMD_MR_PTR_RESET = 4'h1;
  localparam logic [3:0] CMD_RX_RESET     = 4'h2;
  localparam logic [3:0] CMD_TX_RESET     = 4'h3;
  localparam logic [3:0] CMD_ERR_RESET    = 4'h4;
  localparam logic [3:0] CMD_BRK_CLEAR    = 4'h5;

  localparam logic [7:0] CSR_RESET  = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] AUX_RESET  = 8'h00;

  localparam int unsigned DIV_W = 13;
  localparam int unsigned PCLK_HZ_DEFAULT    = 100_000_000;
  localparam int unsigned CRYSTAL_HZ_DEFAULT = 3_686_400;
  // Least ratio of bus clock to crystal so every crystal edge is seen
  localparam int unsigned MIN_CLOCK_RATIO = 4;

  typedef enum logic [1:0] {
    RATE_NORMAL,
    RATE_EXT_I,
    RATE_EXT_II
  } rate_mode_type;

endpackage

// ===== rtl/pin_sync.sv
// Two-flop synchroniser for a group of asynchronous input pins
`timescale 1ns/1ns
module pin_sync #(
  parameter int unsigned WIDTH = 5
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sync_state_type;

  sync_state_type state_ff;
  sync_state_type nxt_state;

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("pin_sync needs WIDTH of at least 1");
    end
  endgenerate

  always_comb begin
    nxt_state      = state_ff;
    nxt_state.meta = async_in;
    nxt_state.sync = state_ff.meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign sync_out = state_ff.sync;

endmodule // pin_sync

// ===== rtl/baud_divider.sv
// Divides crystal edges into one tick per 16x period
`timescale 1ns/1ns
module baud_divider #(
  parameter int unsigned DIV_W = 13
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             step,
  input  wire logic [DIV_W-1:0] divisor,
  output logic                  tick
);

  typedef struct packed {
    logic [DIV_W-1:0] count;
    logic [DIV_W-1:0] last_div;
    logic             tick;
  } div_state_type;

  div_state_type state_ff;
  div_state_type nxt_state;

  generate
    if (DIV_W < 2) begin : g_bad_width
      $error("baud_divider needs DIV_W of at least 2");
    end
  endgenerate

  always_comb begin
    nxt_state          = state_ff;
    nxt_state.tick     = 1'b0;
    nxt_state.last_div = divisor;
    // A new rate restarts the count so no shortened period reaches the shifter
    if (divisor != state_ff.last_div) begin
      nxt_state.count = '0;
    end else if (step) begin
      if (state_ff.count >= divisor - DIV_W'(1)) begin
        nxt_state.count = '0;
        nxt_state.tick  = 1'b1;
      end else begin
        nxt_state.count = state_ff.count + DIV_W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign tick = state_ff.tick;

endmodule // baud_divider

// ===== verif/uart_clk_cmd_properties.sv
// Port checker for the clock select and command block
`timescale 1ns/1ns
module uart_clk_cmd_properties (
  input wire logic        pclk, presetn, psel, penable, pwrite, pready,
  input wire logic [7:0]  paddr, misc_cmd_code,
  input wire logic [31:0] pwdata,
  input wire logic [1:0]  tx_idle, rx_clk_one_x, rx_run, transmit_ready_flag, rx_reset,
  input wire logic [1:0]  transmit_empty_flag, rx_search_start, tx_reset, misc_cmd_strobe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wake_a_ff = 1'b0;
  // Wake-up mode of channel A suppresses the start-bit search, so follow its mode bit
  always @(posedge pclk)
    if (!presetn) wake_a_ff <= 1'b0;
    else if (psel && penable && pready && pwrite && paddr == 8'h40) wake_a_ff <= pwdata[4];
  sequence s_wr(logic [7:0] a);
    psel && penable && pready && pwrite && paddr == a;
  endsequence
  a_rx_one_x: assert property (s_wr(8'h04) |-> ##2
    rx_clk_one_x[0] == ($past(pwdata[7:4], 2) == 4'hf)) else $error("1x select wrong");
  a_rx_search: assert property (s_wr(8'h08) ##0 pwdata[1:0] == 2'h1
    |=> rx_search_start[0] == !wake_a_ff) else $error("start search wrong");
  a_tx_enable: assert property (s_wr(8'h08) ##0 pwdata[7:2] == 6'h01 && tx_idle[0]
    |=> transmit_ready_flag[0] && transmit_empty_flag[0]) else $error("tx flags not set");
  a_tx_disable: assert property (s_wr(8'h08) ##0 pwdata[3]
    |=> !transmit_ready_flag[0] && !transmit_empty_flag[0]) else $error("tx flags kept");
  a_rx_stop: assert property (s_wr(8'h08) ##0 pwdata[1] |=> !rx_run[0])
    else $error("rx still runs");
  a_b_rx_reset: assert property (s_wr(8'h28) ##0 pwdata[7:4] == 4'h2
    |=> rx_reset == 2'h2) else $error("channel B reset wrong");
  a_tx_reset: assert property (s_wr(8'h08) ##0 pwdata[7:4] == 4'h3
    |=> tx_reset[0] ##1 !tx_reset[0]) else $error("tx reset pulse wrong");
  a_misc_code: assert property (s_wr(8'h08) ##0 pwdata[7:4] > 4'h5
    |=> misc_cmd_strobe[0] && misc_cmd_code[3:0] == $past(pwdata[7:4]))
    else $error("misc command wrong");
endmodule // uart_clk_cmd_properties
bind uart_clk_cmd uart_clk_cmd_properties uart_clk_cmd_properties_inst (.*);

// ===== verif/apb_host_model.sv
// Host processor model issuing register bus transfers
`timescale 1ns/1ns
module apb_host_model (
  input  wire logic        pclk, pready, pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel = 1'b0, penable = 1'b0, pwrite = 1'b0,
  output logic      [7:0]  paddr = 8'h00,
  output logic      [31:0] pwdata = 32'h0
);
  logic [31:0] q;
  logic        e;
  // Callers never join an enable with a reset of the same direction
  task automatic xfer(input logic w, input logic [7:0] a, d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Crystal runs at a quarter of the bus rate, so four edges fit in sixteen cycles
    if (w && a[3:0] == 4'h8 && d[7:4] != 4'h0) repeat (16) @(posedge pclk);
  endtask
endmodule // apb_host_model

// ===== verif/uart_clk_cmd_tb.sv
// Self-checking bench for the clock select and command block
`timescale 1ns/1ns
module uart_clk_cmd_tb;
  logic pclk = 1'b0, presetn = 1'b0, timer_tick = 1'b0, psel, penable, pwrite, pready, pslverr;
  logic input_pin_three = 1'b0, input_pin_four = 1'b0, input_pin_five = 1'b0, input_pin_six = 1'b0;
  logic [1:0] xc = 2'h0, tx_idle = 2'h3, tx_fifo_room = 2'h3, rx_clk_tick, tx_clk_tick, rx_run;
  logic [1:0] rx_clk_one_x, tx_clk_one_x, tx_run, transmit_ready_flag, transmit_empty_flag;
  logic [1:0] rx_search_start, mode_register_pointer_reset, rx_reset, tx_reset;
  logic [1:0] error_status_reset, break_change_clear, misc_cmd_strobe;
  logic [7:0] paddr, misc_cmd_code;
  logic [31:0] pwdata, prdata;
  int err_count = 0, tests_run = 0, n_rx, n_tx, n_b, n_cmd[6];
  wire crystal_clock_input = xc[1];
  wire [5:0] cv = {misc_cmd_strobe[0], break_change_clear[0], error_status_reset[0],
                   tx_reset[0], rx_reset[0], mode_register_pointer_reset[0]};
  always #5 pclk = ~pclk;
  always @(posedge pclk) xc <= xc + 2'h1;
  apb_host_model host (.*);
  uart_clk_cmd uart_clk_cmd_inst (.*);
  // Counted on the falling edge so a count reset at a rising edge never races a tick
  always @(negedge pclk) begin
    n_rx += rx_clk_tick[0];
    n_tx += tx_clk_tick[0];
    n_b += rx_clk_tick[1] + tx_clk_tick[1];
    foreach (n_cmd[k]) n_cmd[k] += cv[k];
  end
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic t_regs;
    host.xfer(1, 8'h08, 8'h05);
    host.xfer(0, 8'h50, 8'h00);
    check("status A on", 32'h3f, host.q);
    host.xfer(1, 8'h08, 8'h0a);
    host.xfer(0, 8'h50, 8'h00);
    check("status A off", 32'h0, host.q);
    host.xfer(0, 8'hfc, 8'h00);
    check("unmapped error", 32'h1, {31'h0, host.e});
    host.xfer(1, 8'h40, 8'h18);
    host.xfer(0, 8'h50, 8'h00);
    check("status A multidrop", 32'h10, host.q);
    host.xfer(1, 8'h08, 8'h01);
    host.xfer(1, 8'h40, 8'h00);
    $display("t_regs done");
  endtask
  task automatic t_codes;
    host.xfer(1, 8'h28, 8'h05);
    host.xfer(0, 8'h54, 8'h00);
    check("status B on", 32'h3f, host.q);
    host.xfer(1, 8'h28, 8'h20);
    host.xfer(0, 8'h54, 8'h00);
    check("status B rx reset", 32'h2e, host.q);
    n_cmd = '{default: 0};
    for (int c = 1; c < 10; c++) host.xfer(1, 8'h08, 8'(c << 4));
    for (int k = 0; k < 5; k++) check("command pulse", 32'h1, n_cmd[k]);
    check("misc strobes", 32'h4, n_cmd[5]);
    $display("t_codes done");
  endtask
  task automatic t_rates;
    logic [7:0] t[4][4] = '{'{8'h01, 8'h00, 8'hcc, 8'h18}, '{8'h01, 8'h80, 8'hcc, 8'h0c},
                            '{8'h04, 8'h00, 8'h66, 8'h0c}, '{8'h00, 8'h00, 8'hcc, 8'h04}};
    foreach (t[i]) begin
      host.xfer(1, 8'h40, t[i][0]);
      host.xfer(1, 8'h48, t[i][1]);
      host.xfer(1, 8'h04, t[i][2]);
      repeat (40) @(posedge pclk);
      n_rx = 0;
      n_tx = 0;
      repeat (96) @(posedge pclk);
      check("rx ticks", t[i][3], n_rx);
      check("tx ticks", t[i][3], n_tx);
    end
    $display("t_rates done");
  endtask
  task automatic t_pins;
    host.xfer(1, 8'h04, 8'hfd);
    host.xfer(1, 8'h24, 8'hfe);
    n_rx = 0;
    n_tx = 0;
    n_b = 0;
    repeat (5) begin
      {input_pin_four, input_pin_five, input_pin_six, timer_tick} <= 4'hf;
      @(posedge pclk);
      timer_tick <= 1'b0;
      repeat (4) @(posedge pclk);
      {input_pin_four, input_pin_five, input_pin_six} <= 3'h0;
      repeat (5) @(posedge pclk);
    end
    repeat (8) @(posedge pclk);
    check("pin four ticks", 32'h5, n_rx);
    check("timer ticks", 32'h5, n_tx);
    check("pin five six ticks", 32'ha, n_b);
    check("one x selects", 32'h3, {tx_clk_one_x, rx_clk_one_x});
    $display("t_pins done");
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_codes;
    t_rates;
    t_pins;
    test_done;
  end
  initial begin
    #100000;
    err_count++;
    test_done;
  end
endmodule // uart_clk_cmd_tb
